// file: hdl/epfs_pin_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "epfs_cfg.svh"
module epfs_pin_select
   import epfs_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_deep_standby_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   output logic             o_wb_err,
   output logic      [5:0]  o_addr_out_en,
   output logic             o_chip_select0_out_en,
   output logic             o_addr_latch_out_en,
   output logic             o_lo_group_collective,
   output logic      [7:0]  o_data_hi_out_en,
   output logic      [15:0] o_lo_group_out_en,
   output logic      [2:0]  o_ch11_in_b_alt,
   output logic      [2:0]  o_ch11_out_a_alt,
   output logic      [2:0]  o_ch11_in_a_alt,
   output logic      [2:0]  o_ch10_in_b_alt,
   output logic      [2:0]  o_ch10_out_a_alt,
   output logic      [2:0]  o_ch9_in_b_alt,
   output logic      [2:0]  o_ch9_out_a_alt,
   output logic      [2:0]  o_ch9_in_a_alt,
   output logic      [2:0]  o_ch8_in_b_alt,
   output logic      [2:0]  o_ch8_out_a_alt
);

   // ****************************************
   // Block overview
   // ****************************************

   // Three software registers drive static pin routing
   // Collective word at the lowest address, two select bits only
   // Bus output select word holds the per-signal enables
   // Timer route word picks one of three pins per timer signal
   // All routing is decoded from flops, so nothing but plain decode
   //   gates sits between a register bit and its enable
   // Nothing here drives a pin itself; the pad ring takes the enables

   // Register bus behaviour
   //   A request is taken on an edge with cyc and stb high
   //   Ack or err follows one cycle later, for exactly one cycle
   //   The held request is blanked while ack or err stands
   //   Unmapped words answer err and store nothing
   //   Byte lanes merge one at a time; masked bits never store
   //   Read data stays put until the next read is taken

   // Reset behaviour
   //   Reset is synchronous and active low
   //   Collective and timer words clear on every reset
   //   The bus select word clears only when the reset is not a
   //   deep standby one, so the external bus stays usable on wake
   //   The deep standby flag is only looked at while reset is low

   // Routing timing
   //   A write lands on the edge that raises ack
   //   Enables and alternative choices follow on that same edge
   //   Software may therefore use a pin right after the ack
   //   No routing output waits on a read of any register

   // Software sequence for per-bit control
   //   Clear the collective bit of the group first
   //   Then set the per-bit enables in the bus select word
   //   Setting the collective bit again overrides them at once

   // Limitations
   //   Upper data bus bits beyond the per-bit field are not handled
   //   Timer channels above 11 live elsewhere
   //   Writes to reserved timer bits are dropped, not flagged

   // ****************************************
   // Decode helpers
   // ****************************************

   // Codes are two bits; results are one-hot so the pad mux
   //   needs no second decode
   // Input decode never goes dark: 00 and 01 share alternative 0; only odd A inputs blank, while their route is active
   // Output routes use 00 as off, so reset keeps every timer
   //   output away from its pins
   // An all-zero result only ever means the path is unused

   // Input source: 00 and 01 both pick alternative 0
   function automatic epfs_alt_t epfs_src_dec(input epfs_sel_t code);
      epfs_alt_t r;
      r = 3'h0;
      unique case (code)
         2'h0, 2'h1: r = 3'h1;
         2'h2:       r = 3'h2;
         2'h3:       r = 3'h4;
      endcase
      return r;
   endfunction : epfs_src_dec

   // Output route: 00 drives no pin
   function automatic epfs_alt_t epfs_out_dec(input epfs_sel_t code);
      epfs_alt_t r;
      r = 3'h0;
      unique case (code)
         2'h0: r = 3'h0;
         2'h1: r = 3'h1;
         2'h2: r = 3'h2;
         2'h3: r = 3'h4;
      endcase
      return r;
   endfunction : epfs_out_dec

   // Byte-lane merge under a writable mask
   function automatic logic [31:0] epfs_merge(input logic [31:0] old_val,
                                              input logic [31:0] wdat,
                                              input logic [3:0]  sel,
                                              input logic [31:0] mask);
      logic [31:0] r;
      r = old_val;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      return r & mask;
   endfunction : epfs_merge

   // ****************************************
   // Registers and bus decode
   // ****************************************
   // Word map, byte addressed
   //   Collective word: bit 0 low group, bit 1 high data group
   //   Bus select word: bits 24..17 high data, 16..1 low group,
   //     with 7..2 address lines, 1 chip select, 0 latch enable
   //   Timer route word: two-bit fields, reserved pairs read zero
   // Each word keeps only its writable mask, so reads stay honest
   //   without a separate read mask
   logic [31:0] coll_reg;
   logic [31:0] bus_sel_reg;
   logic [31:0] tmr_reg;
   logic        ack_reg;
   logic        err_reg;
   logic [31:0] rdat_reg;
   logic        req;
   logic        hit_coll;
   logic        hit_bus;
   logic        hit_tmr;
   logic        hit_any;
   logic        wr_go;

   // Ack stays one cycle so a held request is not answered twice
   assign req      = i_wb_cyc & i_wb_stb & ~ack_reg & ~err_reg;
   assign hit_coll = (i_wb_adr == `EPFS_ADDR_COLLECTIVE);
   assign hit_bus  = (i_wb_adr == `EPFS_ADDR_BUS_SEL);
   assign hit_tmr  = (i_wb_adr == `EPFS_ADDR_TIMER);
   assign hit_any  = hit_coll | hit_bus | hit_tmr;
   assign wr_go    = req & i_wb_we & hit_any;

   // Bus answer: ack for mapped words, err for anything else
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         ack_reg <= req & hit_any;
         err_reg <= req & ~hit_any;
      end
   end

   // Read data is pure storage; reading touches no routing
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         rdat_reg <= `EPFS_RST_VAL;
      end else if (req & ~i_wb_we) begin
         if (hit_coll) begin
            rdat_reg <= coll_reg;
         end else if (hit_bus) begin
            rdat_reg <= bus_sel_reg;
         end else if (hit_tmr) begin
            rdat_reg <= tmr_reg;
         end else begin
            rdat_reg <= `EPFS_RST_VAL;
         end
      end
   end

   // Collective overrides; cleared by any system reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         coll_reg <= `EPFS_RST_VAL;
      end else if (wr_go & hit_coll) begin
         coll_reg <= epfs_merge(coll_reg, i_wb_dat, i_wb_sel, `EPFS_COLL_MASK);
      end
   end

   // Written only outside reset, so a deep standby wake cannot
   //   half-load the word; no request is answered during reset,
   //   so nothing is lost by ignoring writes then
   // Bus select keeps its contents when the reset came from deep standby
   always_ff @(posedge i_clk) begin
      if (!i_rst_b && !i_deep_standby_rst) begin
         bus_sel_reg <= `EPFS_RST_VAL;
      end else if (i_rst_b && wr_go && hit_bus) begin
         bus_sel_reg <= epfs_merge(bus_sel_reg, i_wb_dat, i_wb_sel, `EPFS_BUS_MASK);
      end
   end

   // Timer routing; reserved bits are masked so they never store
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         tmr_reg <= `EPFS_RST_VAL;
      end else if (wr_go & hit_tmr) begin
         tmr_reg <= epfs_merge(tmr_reg, i_wb_dat, i_wb_sel, `EPFS_TMR_MASK);
      end
   end

   assign o_wb_dat = rdat_reg;
   assign o_wb_ack = ack_reg;
   assign o_wb_err = err_reg;

   // ****************************************
   // External bus pin gating
   // ****************************************
   logic coll_lo;
   logic coll_hi;
   assign coll_lo = coll_reg[`EPFS_COLL_LO_BIT];
   assign coll_hi = coll_reg[`EPFS_COLL_HI_BIT];

   // ****************************************
   // Named per-signal enables
   // ****************************************

   // One name per enable, so pad wiring can be traced by signal
   logic addr06_out_en;
   logic addr05_out_en;
   logic addr04_out_en;
   logic addr03_out_en;
   logic addr02_out_en;
   logic addr01_out_en;
   logic chip_select0_out_en;
   logic addr_latch_out_en;

   // Per-bit enables come straight from flops, so a write shows next cycle
   assign addr06_out_en       = bus_sel_reg[`EPFS_BUS_A06_BIT];
   assign addr05_out_en       = bus_sel_reg[`EPFS_BUS_A05_BIT];
   assign addr04_out_en       = bus_sel_reg[`EPFS_BUS_A04_BIT];
   assign addr03_out_en       = bus_sel_reg[`EPFS_BUS_A03_BIT];
   assign addr02_out_en       = bus_sel_reg[`EPFS_BUS_A02_BIT];
   assign addr01_out_en       = bus_sel_reg[`EPFS_BUS_A01_BIT];
   // Chip select and latch enable gate their own pins
   assign chip_select0_out_en = bus_sel_reg[`EPFS_BUS_CS0_BIT];
   assign addr_latch_out_en   = bus_sel_reg[`EPFS_BUS_ALE_BIT];

   // Port order puts line 06 in the top bit
   assign o_addr_out_en         = {addr06_out_en, addr05_out_en, addr04_out_en,
                                   addr03_out_en, addr02_out_en, addr01_out_en};
   assign o_chip_select0_out_en = chip_select0_out_en;
   assign o_addr_latch_out_en   = addr_latch_out_en;

   // ****************************************
   // Collective overrides
   // ****************************************

   // The collective bit takes over the whole group; the bus controller
   // then chooses direction itself, so per-bit values are masked off
   // Low group: the flag tells the controller it owns the group
   // High data: forced on, the controller then turns the lines round
   // Trade-off: forcing here leaves the per-bit word untouched, so
   //   clearing the collective bit brings the per-bit setup back
   assign o_lo_group_collective = coll_lo;
   assign o_lo_group_out_en     = coll_lo ? 16'h0000
                                  : bus_sel_reg[`EPFS_BUS_LO_MSB:`EPFS_BUS_LO_LSB];
   assign o_data_hi_out_en      = coll_hi ? 8'hff
                                  : bus_sel_reg[`EPFS_BUS_HI_MSB:`EPFS_BUS_HI_LSB];

   // ****************************************
   // Base timer pin routing
   // ****************************************
   // Each channel has a B input and an A signal
   //   B pins only listen, so B has a source field and nothing else
   //   Even A pins only drive, so they have a route field only
   //   Odd A pins share one pad for both ways, so the route field
   //   wins and the source field is ignored while it is nonzero
   // The timer core sees one-hot choices; it must treat all-zero
   //   as no pin at all
   // Reserved pairs are never stored, so they cannot leak into a field

   // Field slices, named after the signal each one steers
   epfs_sel_t ch11_ib;
   epfs_sel_t ch11_oa;
   epfs_sel_t ch11_ia;
   epfs_sel_t ch10_ib;
   epfs_sel_t ch10_oa;
   epfs_sel_t ch9_ib;
   epfs_sel_t ch9_oa;
   epfs_sel_t ch9_ia;
   epfs_sel_t ch8_ib;
   epfs_sel_t ch8_oa;

   // Slices are as wide as the code type, so no bits are cut
   assign ch11_ib = tmr_reg[`EPFS_CH11_IB_LSB +: $bits(epfs_sel_t)];
   assign ch11_oa = tmr_reg[`EPFS_CH11_OA_LSB +: $bits(epfs_sel_t)];
   assign ch11_ia = tmr_reg[`EPFS_CH11_IA_LSB +: $bits(epfs_sel_t)];
   assign ch10_ib = tmr_reg[`EPFS_CH10_IB_LSB +: $bits(epfs_sel_t)];
   assign ch10_oa = tmr_reg[`EPFS_CH10_OA_LSB +: $bits(epfs_sel_t)];
   assign ch9_ib  = tmr_reg[`EPFS_CH9_IB_LSB +: $bits(epfs_sel_t)];
   assign ch9_oa  = tmr_reg[`EPFS_CH9_OA_LSB +: $bits(epfs_sel_t)];
   assign ch9_ia  = tmr_reg[`EPFS_CH9_IA_LSB +: $bits(epfs_sel_t)];
   assign ch8_ib  = tmr_reg[`EPFS_CH8_IB_LSB +: $bits(epfs_sel_t)];
   assign ch8_oa  = tmr_reg[`EPFS_CH8_OA_LSB +: $bits(epfs_sel_t)];

   // Channel 11: B only listens, A either listens or drives
   assign o_ch11_in_b_alt  = epfs_src_dec(ch11_ib);
   assign o_ch11_out_a_alt = epfs_out_dec(ch11_oa);
   // Odd A pins are one-way: an active output route kills the input path
   assign o_ch11_in_a_alt  = (ch11_oa != `EPFS_ALT_NONE) ? 3'h0
                             : epfs_src_dec(ch11_ia);

   // Channel 10: the even A pin only drives, so it has no source field
   assign o_ch10_in_b_alt  = epfs_src_dec(ch10_ib);
   assign o_ch10_out_a_alt = epfs_out_dec(ch10_oa);

   // Channel 9: same one-way rule as channel 11
   assign o_ch9_in_b_alt   = epfs_src_dec(ch9_ib);
   assign o_ch9_out_a_alt  = epfs_out_dec(ch9_oa);
   assign o_ch9_in_a_alt   = (ch9_oa != `EPFS_ALT_NONE) ? 3'h0
                             : epfs_src_dec(ch9_ia);

   // Channel 8: like channel 10
   assign o_ch8_in_b_alt   = epfs_src_dec(ch8_ib);
   assign o_ch8_out_a_alt  = epfs_out_dec(ch8_oa);

   // ****************************************
   // Integration notes
   // ****************************************

   // The pad ring must give the collective flag priority itself
   //   when the low group is owned by the bus controller
   // Other functions sharing a routed pad must be switched off
   //   by their own registers; this block does not arbitrate
   // The deep standby flag must be stable for the whole reset

endmodule : epfs_pin_select
`default_nettype wire

// file: hdl/epfs_cfg.svh
`ifndef EPFS_CFG_SVH
`define EPFS_CFG_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define EPFS_ADDR_COLLECTIVE 4'h0
`define EPFS_ADDR_BUS_SEL    4'h4
`define EPFS_ADDR_TIMER      4'h8
// ****************************************
// Writable masks and reset values
// ****************************************
`define EPFS_COLL_MASK       32'h0000_0003
`define EPFS_BUS_MASK        32'h01ff_ffff
`define EPFS_TMR_MASK        32'h3f3c_3f3c
`define EPFS_RST_VAL         32'h0000_0000
// ****************************************
// Field positions
// ****************************************
`define EPFS_COLL_LO_BIT     0
`define EPFS_COLL_HI_BIT     1
`define EPFS_BUS_ALE_BIT     0
`define EPFS_BUS_CS0_BIT     1
`define EPFS_BUS_ADDR_LSB    2
`define EPFS_BUS_ADDR_MSB    7
`define EPFS_BUS_A06_BIT     7
`define EPFS_BUS_A05_BIT     6
`define EPFS_BUS_A04_BIT     5
`define EPFS_BUS_A03_BIT     4
`define EPFS_BUS_A02_BIT     3
`define EPFS_BUS_A01_BIT     2
`define EPFS_BUS_LO_LSB      1
`define EPFS_BUS_LO_MSB      16
`define EPFS_BUS_HI_LSB      17
`define EPFS_BUS_HI_MSB      24
`define EPFS_CH11_IB_LSB     28
`define EPFS_CH11_OA_LSB     26
`define EPFS_CH11_IA_LSB     24
`define EPFS_CH10_IB_LSB     20
`define EPFS_CH10_OA_LSB     18
`define EPFS_CH9_IB_LSB      12
`define EPFS_CH9_OA_LSB      10
`define EPFS_CH9_IA_LSB      8
`define EPFS_CH8_IB_LSB      4
`define EPFS_CH8_OA_LSB      2
`define EPFS_ALT_NONE        2'h0
`define EPFS_ALT_LSB         8
`endif

// file: hdl/epfs_pkg.sv
package epfs_pkg;
   // Two-bit route or source code
   typedef logic [1:0] epfs_sel_t;
   // One-hot alternative pin choice, bit n is alternative n
   typedef logic [2:0] epfs_alt_t;
endpackage : epfs_pkg

// file: sim/epfs_pin_select_properties.sv
`timescale 1ns/10ps
`default_nettype none
module epfs_pin_select_properties
   import epfs_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst_b,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [3:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        o_wb_err,
   input wire logic [5:0]  o_addr_out_en,
   input wire logic        o_chip_select0_out_en,
   input wire logic        o_addr_latch_out_en,
   input wire logic        o_lo_group_collective,
   input wire logic [7:0]  o_data_hi_out_en,
   input wire logic [15:0] o_lo_group_out_en,
   input wire logic [2:0]  o_ch11_in_b_alt,
   input wire logic [2:0]  o_ch11_out_a_alt,
   input wire logic [2:0]  o_ch11_in_a_alt
);
   // Request taken this edge; full-word write
   wire rq = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
   wire wf = rq && i_wb_we && (i_wb_sel == 4'hf);
   function automatic logic [2:0] dec_in(input logic [1:0] c);
      return (c == 2'h3) ? 3'h4 : ((c == 2'h2) ? 3'h2 : 3'h1);
   endfunction : dec_in
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_answer; rq |=> (o_wb_ack ^ o_wb_err) ##1 !o_wb_ack && !o_wb_err; endproperty
   a_answer: assert property (p_answer) else $error("bad bus answer");
   property p_addr; wf && i_wb_adr == 4'h4 |=> o_addr_out_en == $past(i_wb_dat[7:2]); endproperty
   a_addr: assert property (p_addr) else $error("address enables wrong");
   property p_cs; wf && i_wb_adr == 4'h4 |=> o_chip_select0_out_en == $past(i_wb_dat[1]); endproperty
   a_cs: assert property (p_cs) else $error("chip select enable wrong");
   property p_ale; wf && i_wb_adr == 4'h4 |=> o_addr_latch_out_en == $past(i_wb_dat[0]); endproperty
   a_ale: assert property (p_ale) else $error("latch enable wrong");
   property p_hi; wf && i_wb_adr == 4'h0 && i_wb_dat[1] |=> o_data_hi_out_en == 8'hff; endproperty
   a_hi: assert property (p_hi) else $error("high data override lost");
   property p_lo; o_lo_group_collective |-> o_lo_group_out_en == 16'h0; endproperty
   a_lo: assert property (p_lo) else $error("low group override lost");
   property p_rsv; rq && !i_wb_we && i_wb_adr == 4'h8 |=> o_wb_dat[31:30] == 2'h0 && o_wb_dat[23:22] == 2'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved field not zero");
   property p_inb; wf && i_wb_adr == 4'h8 |=> o_ch11_in_b_alt == dec_in($past(i_wb_dat[29:28])); endproperty
   a_inb: assert property (p_inb) else $error("input b source wrong");
   property p_out; wf && i_wb_adr == 4'h8 |=> o_ch11_out_a_alt == ($past(i_wb_dat[27:26]) == 2'h0 ? 3'h0 : dec_in($past(i_wb_dat[27:26]))); endproperty
   a_out: assert property (p_out) else $error("output route wrong");
   property p_odd; o_ch11_out_a_alt != 3'h0 |-> o_ch11_in_a_alt == 3'h0; endproperty
   a_odd: assert property (p_odd) else $error("odd input not ignored");
   c_tmr: cover property (wf && i_wb_adr == 4'h8);
   c_err: cover property (o_wb_err);
   c_col: cover property (o_lo_group_collective);
endmodule : epfs_pin_select_properties
bind epfs_pin_select epfs_pin_select_properties u_props (.*);
`default_nettype wire

// file: sim/epfs_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module epfs_pin_model
   import epfs_pkg::*;
(
   input wire logic [2:0] i_alt,
   input wire logic       i_tmr,
   output logic     [2:0] o_pin
);
   // Unselected pins sit at their pull-down level, never the last value
   assign o_pin = i_alt & {3{i_tmr}};
endmodule : epfs_pin_model
`default_nettype wire

// file: sim/epfs_pin_select_bench.sv
`timescale 1ns/10ps
`default_nettype none
module epfs_pin_select_bench import epfs_pkg::*; ;
   logic i_clk = 0, i_rst_b = 0, i_deep_standby_rst = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
   logic [3:0] i_wb_adr = 0, i_wb_sel = 0;
   logic [31:0] i_wb_dat = 0, o_wb_dat, rdat;
   logic o_wb_ack, o_wb_err, o_chip_select0_out_en, o_addr_latch_out_en, o_lo_group_collective;
   logic tmr = 0, got_err;
   logic [5:0] o_addr_out_en;
   logic [7:0] o_data_hi_out_en;
   logic [15:0] o_lo_group_out_en;
   logic [2:0] o_ch11_in_b_alt, o_ch11_out_a_alt, o_ch11_in_a_alt, o_ch10_in_b_alt, o_ch10_out_a_alt;
   logic [2:0] o_ch9_in_b_alt, o_ch9_out_a_alt, o_ch9_in_a_alt, o_ch8_in_b_alt, o_ch8_out_a_alt;
   logic [2:0] pin, ein, eout;
   epfs_sel_t code;
   int mismatches = 0, checks_done = 0, cycles = 0;
   epfs_pin_select dut (.*);
   epfs_pin_model u_pins (.i_alt(o_ch11_out_a_alt), .i_tmr(tmr), .o_pin(pin));
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   // Hang guard: the tests need well under a hundred cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         results();
      end
   end
   task results;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   // Classic cycle; ack is read before the edge's own updates land
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} <= {2'b11, w, a, 4'hf, d};
      do @(posedge i_clk); while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1);
      rdat = o_wb_dat;
      got_err = o_wb_err;
      {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
   endtask : wb
   task rdchk(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      cmp(rdat, e);
   endtask : rdchk
   task rst(input logic deep);
      i_rst_b <= 1'b0;
      i_deep_standby_rst <= deep;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
   endtask : rst
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'b1;
      tmr <= 1'b1;
      rdchk(4'h4, 32'h0);
      rdchk(4'h8, 32'h0);
      wb(1'b1, 4'h4, 32'hfe01_ffa5);
      cmp(o_addr_out_en, 6'h29);
      cmp(o_chip_select0_out_en, 1'b0);
      cmp(o_addr_latch_out_en, 1'b1);
      rdchk(4'h4, 32'h0001_ffa5);
      wb(1'b1, 4'h0, 32'h3);
      cmp(o_data_hi_out_en, 8'hff);
      cmp(o_lo_group_out_en, 16'h0);
      cmp(o_lo_group_collective, 1'b1);
      wb(1'b1, 4'h0, 32'h0);
      cmp(o_lo_group_out_en, 16'hffd2);
      cmp(o_lo_group_collective, 1'b0);
      cmp(o_data_hi_out_en, 8'h00);
      $display("bus select test done");
      for (int c = 0; c < 4; c++) begin
         code = epfs_sel_t'(c);
         ein = (code == 2'h3) ? 3'h4 : ((code == 2'h2) ? 3'h2 : 3'h1);
         eout = (code == 2'h0) ? 3'h0 : ein;
         wb(1'b1, 4'h8, {16{code}});
         rdchk(4'h8, {16{code}} & 32'h3f3c_3f3c);
         cmp(o_ch11_in_b_alt, ein);
         cmp(o_ch11_out_a_alt, eout);
         cmp({o_ch11_in_a_alt, o_ch9_in_a_alt}, (code == 2'h0) ? {ein, ein} : 6'h0);
         cmp(o_ch10_in_b_alt, ein);
         cmp({o_ch9_in_b_alt, o_ch8_in_b_alt}, {ein, ein});
         cmp({o_ch10_out_a_alt, o_ch9_out_a_alt, o_ch8_out_a_alt}, {3{eout}});
         cmp(pin, eout);
      end
      $display("timer route test done");
      wb(1'b1, 4'hc, 32'h1);
      cmp(got_err, 1'b1);
      rst(1'b1);
      rdchk(4'h4, 32'h0001_ffa5);
      rdchk(4'h8, 32'h0);
      rst(1'b0);
      rdchk(4'h4, 32'h0);
      $display("reset test done");
      results();
   end
endmodule : epfs_pin_select_bench
`default_nettype wire
